// ===== rtl/change_alarm_interrupt_coupler.sv
`timescale 1ns/1ps
// How it works
// [RULE1] Sixteen alarm inputs share one level, priority or party-line.
// [RULE2] Any alarm input change raises the interrupt-setting output.
// [RULE3] Per-bit trigger choice: rising, falling or both edges. The code uses one alarm_trig_i setting for all sixteen bits.
// [RULE4] Per-bit detection pulses are ORed into one alarm output.
// [RULE5] The alarm output may set one party-line sub-level request.
// [RULE6] Sixteen external signals each drive their own priority level.
// [RULE7] Each external input triggers on rising or falling transition.
// [RULE8] Eight signals attach as data or service party-line sub-levels.
// [RULE9] Each sub-level presents its own distinct vector location.
// [RULE10] One data coupler slot and one service slot, eight each.
// [RULE11] Host reads the sixteen alarm bits as one word after interrupt.
// [RULE12] External coupler outputs drive priority inputs directly.
// [RULE13] Inputs are synchronised and compared to form one-cycle pulses.
// [RULE14] Requests stay pending until the host acknowledges them.
module change_alarm_interrupt_coupler
	import change_alarm_pkg::*;
#(
	parameter int ALARM_N = change_alarm_pkg::ALARM_BITS,
	parameter int EXT_N = change_alarm_pkg::EXT_LEVELS,
	parameter int SUB_N = change_alarm_pkg::SUB_LEVELS
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [ALARM_N-1:0] alarm_in_i,
	input wire logic [1:0] alarm_trig_i,
	input wire change_alarm_pkg::alarm_route_type alarm_route_i,
	input wire logic [3:0] alarm_prio_sel_i,
	input wire logic [2:0] alarm_sub_sel_i,
	input wire logic alarm_word_rd_i,
	input wire logic [EXT_N-1:0] ext_in_i,
	input wire logic [EXT_N-1:0] ext_rise_i,
	input wire logic [EXT_N-1:0] ext_ack_i,
	input wire logic [SUB_N-1:0] data_sub_in_i,
	input wire logic [SUB_N-1:0] svc_sub_in_i,
	input wire logic [SUB_N-1:0] sub_rise_i,
	input wire change_alarm_pkg::service_ack_type sub_ack_i,
	output logic alarm_pulse_o,
	output logic [ALARM_N-1:0] alarm_word_o,
	output logic [EXT_N-1:0] prio_req_o,
	output logic data_line_req_o,
	output logic svc_line_req_o,
	output logic [SUB_N-1:0] data_pend_o,
	output logic [SUB_N-1:0] svc_pend_o,
	output change_alarm_pkg::vector_req_type data_vec_o,
	output change_alarm_pkg::vector_req_type svc_vec_o
);
	import change_alarm_pkg::*;

	localparam int SYNC_N = ALARM_N + EXT_N + 2 * SUB_N;

	// Lowest pending sub-level wins the vector; used for both lines.
	function automatic logic [2:0] first_set(input logic [SUB_N-1:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = SUB_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : first_set

	logic [SYNC_N-1:0] raw_all, rise_all, fall_all, lvl_all, pulse_all;
	logic [ALARM_N-1:0] alarm_pulses;
	logic [EXT_N-1:0] ext_pulses;
	logic [SUB_N-1:0] data_pulses, svc_pulses;
	logic alarm_any;

	assign raw_all = {svc_sub_in_i, data_sub_in_i, ext_in_i, alarm_in_i};
	assign rise_all = {sub_rise_i, sub_rise_i, ext_rise_i,
		{ALARM_N{alarm_trig_i[0]}}}; // [RULE3] [RULE7]
	assign fall_all = {~sub_rise_i, ~sub_rise_i, ~ext_rise_i,
		{ALARM_N{alarm_trig_i[1]}}}; // [RULE3] [RULE7]

	edge_pulse_bank #(
		.WIDTH(SYNC_N)
	) u_edges (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.sig_i(raw_all),
		.rise_en_i(rise_all),
		.fall_en_i(fall_all),
		.level_o(lvl_all),
		.pulse_o(pulse_all)
	); // [RULE13]

	assign alarm_pulses = pulse_all[ALARM_N-1:0];
	assign ext_pulses = pulse_all[ALARM_N +: EXT_N];
	assign data_pulses = pulse_all[ALARM_N+EXT_N +: SUB_N];
	assign svc_pulses = pulse_all[ALARM_N+EXT_N+SUB_N +: SUB_N];
	assign alarm_any = |alarm_pulses; // [RULE2] [RULE4]

	logic alarm_pulse_ff, nxt_alarm_pulse;
	logic [ALARM_N-1:0] alarm_word_ff, nxt_alarm_word;
	logic [EXT_N-1:0] prio_ff, nxt_prio;
	logic [SUB_N-1:0] data_ff, nxt_data, svc_ff, nxt_svc;
	vector_req_type data_vec_ff, nxt_data_vec, svc_vec_ff, nxt_svc_vec;

	always_comb begin
		nxt_alarm_pulse = alarm_any; // [RULE4]
		nxt_alarm_word = alarm_word_ff;
		if (alarm_word_rd_i) begin
			nxt_alarm_word = lvl_all[ALARM_N-1:0]; // [RULE11]
		end
		// Set wins over acknowledge so an edge in the ack cycle is kept.
		nxt_prio = (prio_ff & ~ext_ack_i) | ext_pulses; // [RULE6] [RULE14]
		nxt_data = data_ff;
		nxt_svc = svc_ff;
		if (sub_ack_i.valid && !sub_ack_i.service_line) begin
			nxt_data[sub_ack_i.sub_level] = 1'b0; // [RULE14]
		end
		if (sub_ack_i.valid && sub_ack_i.service_line) begin
			nxt_svc[sub_ack_i.sub_level] = 1'b0; // [RULE14]
		end
		nxt_data = nxt_data | data_pulses; // [RULE8] [RULE10]
		nxt_svc = nxt_svc | svc_pulses; // [RULE8] [RULE10]
		unique case (alarm_route_i) // [RULE1]
			ROUTE_PRIORITY: begin
				nxt_prio[alarm_prio_sel_i] = 1'b1 & alarm_any |
					nxt_prio[alarm_prio_sel_i];
			end
			ROUTE_DATA_LINE: begin
				nxt_data[alarm_sub_sel_i] = alarm_any |
					nxt_data[alarm_sub_sel_i]; // [RULE5]
			end
			ROUTE_SERVICE_LINE: begin
				nxt_svc[alarm_sub_sel_i] = alarm_any |
					nxt_svc[alarm_sub_sel_i]; // [RULE5]
			end
			default: begin
			end
		endcase
		nxt_data_vec.valid = |nxt_data;
		nxt_data_vec.line_level = DATA_LINE_LEVEL;
		nxt_data_vec.sub_level = first_set(nxt_data); // [RULE9]
		nxt_svc_vec.valid = |nxt_svc;
		nxt_svc_vec.line_level = SERVICE_LINE_LEVEL;
		nxt_svc_vec.sub_level = first_set(nxt_svc); // [RULE9]
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			alarm_pulse_ff <= 1'b0;
			alarm_word_ff <= RESET_WORD;
			prio_ff <= '0;
			data_ff <= '0;
			svc_ff <= '0;
			data_vec_ff <= '0;
			svc_vec_ff <= '0;
		end else begin
			alarm_pulse_ff <= nxt_alarm_pulse;
			alarm_word_ff <= nxt_alarm_word;
			prio_ff <= nxt_prio;
			data_ff <= nxt_data;
			svc_ff <= nxt_svc;
			data_vec_ff <= nxt_data_vec;
			svc_vec_ff <= nxt_svc_vec;
		end
	end

	assign alarm_pulse_o = alarm_pulse_ff;
	assign alarm_word_o = alarm_word_ff;
	assign prio_req_o = prio_ff; // [RULE12]
	assign data_pend_o = data_ff;
	assign svc_pend_o = svc_ff;
	assign data_line_req_o = data_vec_ff.valid;
	assign svc_line_req_o = svc_vec_ff.valid;
	assign data_vec_o = data_vec_ff;
	assign svc_vec_o = svc_vec_ff;
endmodule : change_alarm_interrupt_coupler

// ===== common/change_alarm_pkg.sv
package change_alarm_pkg;
	localparam int ALARM_BITS = 16;
	localparam int EXT_LEVELS = 16;
	localparam int SUB_LEVELS = 8;
	// Party-line level numbers of the data and service lines.
	localparam logic [4:0] DATA_LINE_LEVEL = 5'h0C;
	localparam logic [4:0] SERVICE_LINE_LEVEL = 5'h0D;
	localparam logic [1:0] TRIG_RISE = 2'h1;
	localparam logic [1:0] TRIG_FALL = 2'h2;
	localparam logic [1:0] TRIG_BOTH = 2'h3;
	localparam logic [ALARM_BITS-1:0] RESET_WORD = 16'h0000;

	typedef enum logic [1:0] {
		ROUTE_PRIORITY = 2'h0,
		ROUTE_DATA_LINE = 2'h1,
		ROUTE_SERVICE_LINE = 2'h3
	} alarm_route_type;

	// Vector request to the host: which party line and which sub-level.
	typedef struct packed {
		logic valid;
		logic [4:0] line_level;
		logic [2:0] sub_level;
	} vector_req_type;

	typedef struct packed {
		logic valid;
		logic service_line;
		logic [2:0] sub_level;
	} service_ack_type;
endpackage : change_alarm_pkg

// ===== rtl/edge_pulse_bank.sv
`timescale 1ns/1ps
module edge_pulse_bank #(
	parameter int WIDTH = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] sig_i,
	input wire logic [WIDTH-1:0] rise_en_i,
	input wire logic [WIDTH-1:0] fall_en_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] pulse_o
);
	logic [WIDTH-1:0] meta_ff, sync_ff, prev_ff;
	logic [WIDTH-1:0] nxt_meta, nxt_sync, nxt_prev;

	always_comb begin
		nxt_meta = sig_i;
		nxt_sync = meta_ff;
		nxt_prev = sync_ff;
	end

	// Two stages before use; sync_ff and its delayed copy prev_ff feed the comparator.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	assign level_o = sync_ff;
	assign pulse_o = (sync_ff & ~prev_ff & rise_en_i) |
		(~sync_ff & prev_ff & fall_en_i); // [RULE13]
endmodule : edge_pulse_bank

// ===== tb/coupler_properties.sv
`timescale 1ns/1ps
module coupler_properties
	import change_alarm_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] alarm_in_i,
	input wire logic [1:0] alarm_trig_i,
	input wire logic alarm_word_rd_i,
	input wire logic [15:0] ext_in_i,
	input wire logic [15:0] ext_rise_i,
	input wire logic [15:0] ext_ack_i,
	input wire logic alarm_pulse_o,
	input wire logic [15:0] alarm_word_o,
	input wire logic [15:0] prio_req_o,
	input wire logic data_line_req_o,
	input wire logic [7:0] data_pend_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Six quiet cycles outlast the synchroniser, so no edge is in flight.
	sequence calm_alarm; $stable(alarm_in_i) [*6]; endsequence
	sequence calm_ext; $stable(ext_in_i[0]) [*4]; endsequence
	AST_EXT_RISE: assert property ($rose(ext_in_i[0]) && ext_rise_i[0]
		|-> ##[1:4] prio_req_o[0]) else $error("no rise request");
	AST_EXT_FALL: assert property ($fell(ext_in_i[8]) && !ext_rise_i[8]
		|-> ##[1:4] prio_req_o[8]) else $error("no fall request");
	AST_EXT_HOLD: assert property (prio_req_o[0] && !ext_ack_i[0]
		|=> prio_req_o[0]) else $error("request lost");
	AST_EXT_CLR: assert property (calm_ext ##0 ext_ack_i[0]
		|-> ##[1:2] !prio_req_o[0]) else $error("request kept");
	AST_ALARM_BOTH: assert property (alarm_trig_i == TRIG_BOTH
		&& $changed(alarm_in_i) |-> ##[1:4] alarm_pulse_o) else $error("no alarm");
	AST_ALARM_QUIET: assert property (calm_alarm |-> !alarm_pulse_o)
		else $error("stray alarm");
	AST_WORD: assert property (calm_alarm ##0 alarm_word_rd_i
		|-> ##[1:2] alarm_word_o == alarm_in_i) else $error("bad word");
	AST_LINE_REQ: assert property (data_line_req_o
		== (data_pend_o != 8'h00)) else $error("line request wrong");
endmodule : coupler_properties

// ===== tb/host_irq_model.sv
`timescale 1ns/1ps
module host_irq_model
	import change_alarm_pkg::*;
(
	input wire logic clk_i,
	input wire logic ack_en_i,
	input wire logic [15:0] prio_req_i,
	input wire change_alarm_pkg::vector_req_type data_vec_i,
	input wire change_alarm_pkg::vector_req_type svc_vec_i,
	output logic [15:0] ext_ack_o,
	output change_alarm_pkg::service_ack_type sub_ack_o
);
	// Acks are one-cycle pulses; the gap keeps a stale vector unacked twice.
	// The acks settle to zero at the first edge, while reset still holds.
	always @(posedge clk_i) begin
		ext_ack_o <= ack_en_i ? prio_req_i & ~ext_ack_o : 16'h0000;
		sub_ack_o.valid <= ack_en_i && !sub_ack_o.valid
			&& (data_vec_i.valid || svc_vec_i.valid);
		sub_ack_o.service_line <= !data_vec_i.valid;
		sub_ack_o.sub_level <= data_vec_i.valid ? data_vec_i.sub_level
			: svc_vec_i.sub_level;
	end
endmodule : host_irq_model

// ===== tb/change_alarm_interrupt_coupler_test.sv
`timescale 1ns/1ps
module change_alarm_interrupt_coupler_test;
	import change_alarm_pkg::*;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, alarm_word_rd_i = 1'b0, ack_en = 1'b0;
	logic [15:0] alarm_in_i = 16'h0000, ext_in_i = 16'hFF00;
	logic [1:0] alarm_trig_i = TRIG_BOTH;
	logic [2:0] alarm_sub_sel_i = 3'h0;
	logic [3:0] alarm_prio_sel_i = 4'h5;
	alarm_route_type alarm_route_i = ROUTE_DATA_LINE;
	logic [7:0] data_sub_i = 8'h00, svc_sub_i = 8'h00, data_pend, svc_pend;
	logic [15:0] ext_ack, prio_req, alarm_word;
	logic pulse, data_req, svc_req;
	service_ack_type sub_ack;
	vector_req_type data_vec, svc_vec;
	int n_errors = 0, n_compared = 0, n_cycles = 0, n_pulse = 0;
	change_alarm_interrupt_coupler dut_u (.clk_i, .sys_rst_i, .alarm_in_i,
		.alarm_trig_i, .alarm_route_i, .alarm_prio_sel_i,
		.alarm_sub_sel_i, .alarm_word_rd_i, .ext_in_i, .ext_rise_i(16'h00FF),
		.ext_ack_i(ext_ack), .data_sub_in_i(data_sub_i), .svc_sub_in_i(svc_sub_i),
		.sub_rise_i(8'hFF), .sub_ack_i(sub_ack), .alarm_pulse_o(pulse),
		.alarm_word_o(alarm_word), .prio_req_o(prio_req),
		.data_line_req_o(data_req), .svc_line_req_o(svc_req),
		.data_pend_o(data_pend), .svc_pend_o(svc_pend), .data_vec_o(data_vec),
		.svc_vec_o(svc_vec));
	host_irq_model host_u (.clk_i, .ack_en_i(ack_en), .prio_req_i(prio_req),
		.data_vec_i(data_vec), .svc_vec_i(svc_vec), .ext_ack_o(ext_ack),
		.sub_ack_o(sub_ack));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n_cycles <= n_cycles + 1;
		if (n_cycles == 1000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Samples just after the edge so outputs have settled.
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_i);
			#1 n_pulse += (pulse === 1'b1);
		end
	endtask : step
	task automatic ext_edges();
		step(5);
		check("prio_req", prio_req, 16'h0000);
		@(posedge clk_i);
		ext_in_i <= 16'h00FF;
		step(5);
		check("prio_req", prio_req, 16'hFFFF);
		@(posedge clk_i);
		ack_en <= 1'b1;
		step(5);
		check("prio_req", prio_req, 16'h0000);
		@(posedge clk_i);
		ack_en <= 1'b0;
	endtask : ext_edges
	task automatic alarm_trigs();
		for (int t = 1; t <= 3; t++) begin
			@(posedge clk_i);
			n_pulse = 0;
			alarm_trig_i <= t[1:0];
			alarm_sub_sel_i <= t[2:0];
			alarm_in_i <= 16'h8010;
			step(6);
			@(posedge clk_i);
			alarm_in_i <= 16'h0000;
			step(6);
			check("pulses", 16'(n_pulse), 16'(t == 3 ? 2 : 1));
		end
		@(posedge clk_i);
		alarm_in_i <= 16'hA5C3;
		step(7);
		@(posedge clk_i);
		alarm_word_rd_i <= 1'b1;
		@(posedge clk_i);
		alarm_word_rd_i <= 1'b0;
		step(2);
		check("alarm_word", alarm_word, 16'hA5C3);
		check("data_pend", {8'h00, data_pend}, 16'h000E);
		check("data_vec", {7'h00, data_vec},
			{7'h00, 1'b1, DATA_LINE_LEVEL, 3'h1});
	endtask : alarm_trigs
	task automatic party_lines();
		@(posedge clk_i);
		data_sub_i <= 8'h01;
		svc_sub_i <= 8'hA0;
		step(5);
		check("data_pend", {8'h00, data_pend}, 16'h000F);
		check("svc_pend", {8'h00, svc_pend}, 16'h00A0);
		check("svc_vec", {7'h00, svc_vec},
			{7'h00, 1'b1, SERVICE_LINE_LEVEL, 3'h5});
		check("line_reqs", {14'h0000, data_req, svc_req}, 16'h0003);
		@(posedge clk_i);
		ack_en <= 1'b1;
		step(40);
		check("pend", {data_pend, svc_pend}, 16'h0000);
	endtask : party_lines
	// The host stops acking first, so the alarm's requests stay visible.
	task automatic alarm_routes();
		@(posedge clk_i);
		ack_en <= 1'b0;
		alarm_route_i <= ROUTE_PRIORITY;
		step(2);
		@(posedge clk_i);
		alarm_in_i <= 16'h25C3;
		step(5);
		check("prio_req", prio_req, 16'h0020);
		@(posedge clk_i);
		alarm_route_i <= ROUTE_SERVICE_LINE;
		alarm_sub_sel_i <= 3'h6;
		alarm_in_i <= 16'hA5C3;
		step(5);
		check("svc_pend", {8'h00, svc_pend}, 16'h0040);
		check("prio_req", prio_req, 16'h0020);
	endtask : alarm_routes
	task automatic tally_and_finish();
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		ext_edges();
		alarm_trigs();
		party_lines();
		alarm_routes();
		tally_and_finish();
	end
endmodule : change_alarm_interrupt_coupler_test
bind change_alarm_interrupt_coupler coupler_properties prop_u (.*);
